// *** design/hpc_port_config.sv ***
// Summary of operation
// R1: Bits 5:4 of byte two pick an over-current filter delay of 50, 100, 200 or 400 ns.
// R2: Bit 3 of byte two makes the hub report itself as part of a compound device.
// R3: The configuring party must also mark the embedded function's port as non-removable.
// R4: With strap configuration, any non-removable strap forces the compound report.
// R5: Byte three bit 3 low selects standard mode, where physical port n is reported as n.
// R6: In standard mode enabled ports above a disabled one are renumbered downward.
// R7: Standard mode takes port enables from straps or the self and bus powered disable bytes, reset zero.
// R8: Byte three bit 3 high takes reported numbers from two map registers, reset zero.
// R9: In the fixed-attach byte bits 1 to 3 mark ports 1 to 3 non-removable; other bits reserved.
// R10: The hub reports which active ports hold a permanently attached device.
// R11: Under internal defaults the non-removable marks come from two strap pins.
// R12: Firmware must set fixed-attach bit 1 so the internal reader is seen as fixed.
// R13: Ports disabled in any order give a correct enabled count and reordered active ports.
// R14: Reserved bits read as zero and writes to them do nothing.
module hpc_port_config
(
   input  wire logic                     clk,          // Core clock, 50 MHz
   input  wire logic                     sys_rst,      // Async reset, active high
   input  wire logic                     clk_en,       // Freezes all state when low
   input  wire logic [7:0]               reg_addr,     // Register address
   input  wire logic [7:0]               reg_wdata,    // Write data
   input  wire logic                     reg_wr,       // Write strobe
   input  wire logic                     reg_rd,       // Read strobe
   output logic      [7:0]               reg_rdata,    // Read data, cycle after strobe
   input  wire logic                     strap_mode,   // Pin: config from straps/defaults
   input  wire logic                     self_powered, // Pin level: self-powered operation
   input  wire logic [1:0]               fixed_attach_straps, // Pins: non-removable marks
   input  wire logic [1:0]               port_dis_straps,     // Pins: port disables
   input  wire logic [2:0]               oc_sense,     // Pins: raw over-current per port
   output logic      [2:0]               oc_fault,     // Filtered over-current per port
   output hpc_pkg::hpc_report_t          report,       // Summary for enumeration
   output logic      [5:0]               port_number   // Reported number per physical port, 2 bits each
);
   // Software registers
   logic [7:0] cfg_two_reg;
   logic [7:0] cfg_three_reg;
   logic [7:0] fixed_reg;
   logic [7:0] dis_self_reg;
   logic [7:0] dis_bus_reg;
   logic [7:0] map_12_reg;
   logic [7:0] map_3_reg;

   // Pin synchronisers, first stage feeds only the second
   logic [6:0] pin_meta_reg;
   logic [6:0] pin_sync_reg;
   logic [2:0] oc_meta_reg;
   logic [2:0] oc_sync_reg;

   logic       s_strap;
   logic       s_self;
   logic [1:0] s_fixed;
   logic [1:0] s_dis;

   assign s_strap = pin_sync_reg[0];
   assign s_self  = pin_sync_reg[1];
   assign s_fixed = pin_sync_reg[3:2];
   assign s_dis   = pin_sync_reg[5:4];

   // Two-flop synchronisers for every pin
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_meta_reg <= 7'h00;
         pin_sync_reg <= 7'h00;
         oc_meta_reg  <= 3'h0;
         oc_sync_reg  <= 3'h0;
      end
      else if (clk_en)
      begin
         pin_meta_reg <= {1'b0, port_dis_straps, fixed_attach_straps, self_powered, strap_mode};
         pin_sync_reg <= pin_meta_reg;
         oc_meta_reg  <= oc_sense;
         oc_sync_reg  <= oc_meta_reg;
      end
   end

   // Address decode
   logic hit_two;
   logic hit_three;
   logic hit_fixed;
   logic hit_dis_s;
   logic hit_dis_b;
   logic hit_map12;
   logic hit_map3;
   logic hit_stat;
   logic hit_map_out;
   assign hit_two     = reg_addr == hpc_pkg::ADDR_CFG_TWO;
   assign hit_three   = reg_addr == hpc_pkg::ADDR_CFG_THREE;
   assign hit_fixed   = reg_addr == hpc_pkg::ADDR_FIXED;
   assign hit_dis_s   = reg_addr == hpc_pkg::ADDR_DIS_SELF;
   assign hit_dis_b   = reg_addr == hpc_pkg::ADDR_DIS_BUS;
   assign hit_map12   = reg_addr == hpc_pkg::ADDR_MAP_12;
   assign hit_map3    = reg_addr == hpc_pkg::ADDR_MAP_3;
   assign hit_stat    = reg_addr == hpc_pkg::ADDR_STATUS;
   assign hit_map_out = reg_addr == hpc_pkg::ADDR_MAP_OUT;

   // Register writes; masks drop reserved bits so they never steer logic
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_two_reg   <= hpc_pkg::RESET_BYTE;
         cfg_three_reg <= hpc_pkg::RESET_BYTE;
         fixed_reg     <= hpc_pkg::RESET_BYTE;
         dis_self_reg  <= hpc_pkg::RESET_BYTE; // see R7
         dis_bus_reg   <= hpc_pkg::RESET_BYTE; // see R7
         map_12_reg    <= hpc_pkg::RESET_BYTE; // see R8
         map_3_reg     <= hpc_pkg::RESET_BYTE; // see R8
      end
      else if (clk_en && reg_wr)
      begin
         if (hit_two)
            cfg_two_reg <= reg_wdata & hpc_pkg::MASK_CFG_TWO; // see R14
         else if (hit_three)
            cfg_three_reg <= reg_wdata & hpc_pkg::MASK_CFG_THREE; // see R14
         else if (hit_fixed)
            fixed_reg <= reg_wdata & hpc_pkg::MASK_PORTS; // see R9
         else if (hit_dis_s)
            dis_self_reg <= reg_wdata & hpc_pkg::MASK_PORTS;
         else if (hit_dis_b)
            dis_bus_reg <= reg_wdata & hpc_pkg::MASK_PORTS;
         else if (hit_map12)
            map_12_reg <= reg_wdata & hpc_pkg::MASK_MAP_12;
         else if (hit_map3)
            map_3_reg <= reg_wdata & hpc_pkg::MASK_MAP_3;
      end
   end

   // Effective fixed-attach and disable masks, per physical port 1..3
   logic [2:0] fixed_eff;
   logic [2:0] dis_eff;
   hpc_pkg::hpc_mode_t mode;
   assign fixed_eff = s_strap ? {1'b0, s_fixed}                                         // see R11
                              : fixed_reg[hpc_pkg::PORT_LSB +: hpc_pkg::NUM_PORTS];    // see R9
   assign dis_eff   = s_strap ? {1'b0, s_dis}
                              : (s_self ? dis_self_reg[hpc_pkg::PORT_LSB +: hpc_pkg::NUM_PORTS]
                                        : dis_bus_reg[hpc_pkg::PORT_LSB +: hpc_pkg::NUM_PORTS]); // see R7
   assign mode      = hpc_pkg::hpc_mode_t'(cfg_three_reg[hpc_pkg::REMAP_BIT]);

   // Compound report: register bit, or with straps only the OR of the strap fixed ports.
   // The firmware is trusted to mark the embedded port itself (see R3, R12).
   logic compound_eff;
   assign compound_eff = s_strap ? (|fixed_eff)                         // see R4
                                 : cfg_two_reg[hpc_pkg::COMPOUND_BIT]; // see R2

   // Per-port number: contiguous count in standard mode, low two bits of the map nibble in remap mode.
   // A disabled port reports zero in standard mode; a zero map entry also means unused.
   logic [1:0] num_next [hpc_pkg::NUM_PORTS];
   logic [1:0] rank     [hpc_pkg::NUM_PORTS + 1];
   logic [2:0] active;
   logic [3:0] map_nib  [hpc_pkg::NUM_PORTS];
   assign rank[0]    = 2'h0;
   assign map_nib[0] = map_12_reg[3:0];
   assign map_nib[1] = map_12_reg[7:4];
   assign map_nib[2] = map_3_reg[3:0];

   genvar gi;
   generate
      for (gi = 0; gi < hpc_pkg::NUM_PORTS; gi++)
      begin : g_port
         // Running count of enabled ports below gives the downward renumbering
         assign rank[gi + 1] = rank[gi] + {1'b0, ~dis_eff[gi]}; // see R6 see R13
         assign num_next[gi] = (mode == hpc_pkg::HPC_MODE_REMAP) ? map_nib[gi][1:0]              // see R8
                             : (dis_eff[gi] ? 2'h0 : rank[gi + 1]);                              // see R5
         assign active[gi]   = (num_next[gi] != 2'h0);
      end
   endgenerate

   // Enabled count and per-active-port fixed flags, indexed by reported number
   logic [1:0] count_next;
   logic [2:0] fixed_rep;
   always_comb
   begin
      count_next = 2'h0;
      fixed_rep  = 3'h0;
      for (int i = 0; i < hpc_pkg::NUM_PORTS; i++)
      begin
         if (active[i])
         begin
            count_next = count_next + 2'h1; // see R13
            if (fixed_eff[i])
               fixed_rep[num_next[i] - 2'h1] = 1'b1; // see R10
         end
      end
   end

   // Registered outputs for enumeration
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         report      <= '0;
         port_number <= 6'h00;
      end
      else if (clk_en)
      begin
         report.compound   <= compound_eff;
         report.port_count <= count_next;
         report.fixed_mask <= fixed_rep; // see R10
         port_number       <= {num_next[2], num_next[1], num_next[0]};
      end
   end

   // Read mux, unmapped addresses read zero
   logic [7:0] rd_next;
   assign rd_next = hit_two     ? cfg_two_reg :
                    hit_three   ? cfg_three_reg :
                    hit_fixed   ? fixed_reg :
                    hit_dis_s   ? dis_self_reg :
                    hit_dis_b   ? dis_bus_reg :
                    hit_map12   ? map_12_reg :
                    hit_map3    ? map_3_reg :
                    hit_stat    ? {s_strap, compound_eff, count_next, 1'b0, dis_eff} :
                    hit_map_out ? {2'b00, num_next[2], num_next[1], num_next[0]} : 8'h00;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (clk_en)
         reg_rdata <= reg_rd ? rd_next : 8'h00;
   end

   // Over-current filters share one delay code
   genvar go;
   generate
      for (go = 0; go < hpc_pkg::NUM_PORTS; go++)
      begin : g_oc
         hpc_oc_filter u_filt
         (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .clk_en    (clk_en),
            .delay_sel (cfg_two_reg[hpc_pkg::OC_LSB +: 2]), // see R1
            .oc_raw    (oc_sync_reg[go]),
            .oc_out    (oc_fault[go])
         );
      end
   endgenerate
endmodule

// *** design/hpc_pkg.sv ***
package hpc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_CFG_TWO   = 8'he5;
   localparam logic [7:0] ADDR_CFG_THREE = 8'he6;
   localparam logic [7:0] ADDR_FIXED     = 8'he7;
   localparam logic [7:0] ADDR_DIS_SELF  = 8'he8;
   localparam logic [7:0] ADDR_DIS_BUS   = 8'he9;
   localparam logic [7:0] ADDR_MAP_12    = 8'hfb;
   localparam logic [7:0] ADDR_MAP_3     = 8'hfc;
   localparam logic [7:0] ADDR_STATUS    = 8'hf0;
   localparam logic [7:0] ADDR_MAP_OUT   = 8'hf1;

   // Writable bit masks, reserved bits stay zero
   localparam logic [7:0] MASK_CFG_TWO   = 8'h3c;
   localparam logic [7:0] MASK_CFG_THREE = 8'h08;
   localparam logic [7:0] MASK_PORTS     = 8'h0e;
   localparam logic [7:0] MASK_MAP_12    = 8'hff;
   localparam logic [7:0] MASK_MAP_3     = 8'h0f;
   localparam logic [7:0] RESET_BYTE     = 8'h00;

   // Field positions
   localparam int OC_LSB       = 4;
   localparam int COMPOUND_BIT = 3;
   localparam int REMAP_BIT    = 3;
   localparam int PORT_LSB     = 1;
   localparam int NUM_PORTS    = 3;

   // Over-current filter delay choices
   localparam int OC_DELAY_0_NS = 50;
   localparam int OC_DELAY_1_NS = 100;
   localparam int OC_DELAY_2_NS = 200;
   localparam int OC_DELAY_3_NS = 400;
   localparam int CLK_PERIOD_NS = 20;
   localparam logic [4:0] OC_CYC_0 = 5'((OC_DELAY_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] OC_CYC_1 = 5'((OC_DELAY_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] OC_CYC_2 = 5'((OC_DELAY_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] OC_CYC_3 = 5'((OC_DELAY_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Descriptor-facing summary for the enumeration logic
   typedef struct packed {
      logic       compound;   // Hub reported as compound device
      logic [1:0] port_count; // Number of enabled ports
      logic [2:0] fixed_mask; // Non-removable, per reported active port
   } hpc_report_t;

   typedef enum logic [0:0] {
      HPC_MODE_STANDARD = 1'b0,
      HPC_MODE_REMAP    = 1'b1
   } hpc_mode_t;
endpackage

// *** design/hpc_oc_filter.sv ***
// Over-current filter: the fault must persist for the selected delay
module hpc_oc_filter
(
   input  wire logic       clk,       // Core clock
   input  wire logic       sys_rst,   // Async reset
   input  wire logic       clk_en,    // Freeze when low
   input  wire logic [1:0] delay_sel, // Delay code
   input  wire logic       oc_raw,    // Synchronised raw fault
   output logic            oc_out     // Filtered fault
);
   logic [4:0] cnt_reg;
   logic [4:0] limit;

   // Round-up cycle counts keep the delay at least as long as chosen
   assign limit = (delay_sel == 2'b00) ? hpc_pkg::OC_CYC_0 :
                  (delay_sel == 2'b01) ? hpc_pkg::OC_CYC_1 :
                  (delay_sel == 2'b10) ? hpc_pkg::OC_CYC_2 : hpc_pkg::OC_CYC_3; // see R1

   // Count while the fault stands, drop at once when it clears
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_reg <= 5'h00;
         oc_out  <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!oc_raw)
         begin
            cnt_reg <= 5'h00;
            oc_out  <= 1'b0;
         end
         else if (cnt_reg >= limit - 5'h01)
            oc_out <= 1'b1; // see R1
         else
            cnt_reg <= cnt_reg + 5'h01;
      end
   end
endmodule

// *** sim/hpc_port_config_sva.sv ***
// Watches the register bus and the enumeration summary at the ports
module hpc_chk
(
   input wire logic                 clk,         // Core clock
   input wire logic                 sys_rst,     // Async reset
   input wire logic                 clk_en,      // Clock enable
   input wire logic [7:0]           reg_addr,    // Address
   input wire logic [7:0]           reg_wdata,   // Write data
   input wire logic                 reg_wr,      // Write strobe
   input wire logic                 reg_rd,      // Read strobe
   input wire logic [7:0]           reg_rdata,   // Read data
   input wire logic                 strap_mode,  // Strap pin
   input wire logic [2:0]           oc_sense,    // Raw fault pins
   input wire logic [2:0]           oc_fault,    // Filtered faults
   input wire hpc_pkg::hpc_report_t report,      // Summary
   input wire logic [5:0]           port_number  // Reported numbers
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Decoded bus events and the count of live port numbers
   wire logic       rd_on  = reg_rd && clk_en;
   wire logic       e5_wr  = reg_wr && clk_en && reg_addr == 8'he5;
   wire logic [1:0] n_live = 2'(port_number[1:0] != 2'h0) + 2'(port_number[3:2] != 2'h0)
                             + 2'(port_number[5:4] != 2'h0);
   // Reported numbers in use, bit k for number k+1; a remap may leave gaps in the numbering
   wire logic [2:0] n_used = 3'(((4'h1 << port_number[1:0]) | (4'h1 << port_number[3:2])
                             | (4'h1 << port_number[5:4])) >> 1);

   // Strap pin must be settled low, else the compound flag follows straps
   sequence s_e5_wr;
      (!strap_mode)[*3] ##0 e5_wr ##1 (!e5_wr && !strap_mode);
   endsequence
   property p_comp;
      s_e5_wr |=> report.compound == $past(reg_wdata[3], 2);
   endproperty
   property p_cfg2_res;
      rd_on && reg_addr == 8'he5 |=> (reg_rdata & 8'hc3) == 8'h00;
   endproperty
   property p_fix_res;
      rd_on && reg_addr == 8'he7 |=> (reg_rdata & 8'hf1) == 8'h00;
   endproperty
   property p_unmap;
      rd_on && reg_addr[7:5] != 3'h7 |=> reg_rdata == 8'h00;
   endproperty
   property p_count;
      report.port_count == n_live;
   endproperty
   property p_fix_act;
      (report.fixed_mask & ~n_used) == 3'h0;
   endproperty
   // Shortest delay still needs the pins high through the synchroniser
   property p_oc_rise;
      $rose(oc_fault[0]) |-> $past(oc_sense[0], 3) && $past(oc_sense[0], 4);
   endproperty
   property p_oc_fall;
      $fell(oc_sense[0]) |-> ##[1:6] !oc_fault[0];
   endproperty

   a_comp: assert property (p_comp) else $error("compound flag wrong");
   a_cfg2_res: assert property (p_cfg2_res) else $error("byte two reserved set");
   a_fix_res: assert property (p_fix_res) else $error("fixed mask reserved set");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_count: assert property (p_count) else $error("port count wrong");
   a_fix_act: assert property (p_fix_act) else $error("fixed mark on idle port");
   a_oc_rise: assert property (p_oc_rise) else $error("fault rose early");
   a_oc_fall: assert property (p_oc_fall) else $error("fault stuck");
endmodule

bind hpc_port_config hpc_chk u_chk (.clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .strap_mode, .oc_sense, .oc_fault, .report, .port_number);

// *** sim/hpc_host_model.sv ***
// Upstream host: latches the port count the hub offers at enumeration
module hpc_host_model
(
   input  wire logic                 clk,        // Core clock
   input  wire logic                 take,       // Enumerate now
   input  wire hpc_pkg::hpc_report_t report,     // Hub summary
   output logic      [1:0]           ports_seen  // Ports found
);
   timeunit 1ns;
   timeprecision 1ns;
   // Only the count is kept; descriptors of fixed devices are not fetched
   always_ff @(posedge clk)
      if (take)
         ports_seen <= report.port_count;
endmodule

// *** sim/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk = 1'b0;
   logic                sys_rst = 1'b1;
   logic                clk_en = 1'b1;
   logic [7:0]          reg_addr = 8'h00;
   logic [7:0]          reg_wdata = 8'h00;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic                strap_mode = 1'b0;
   logic                self_powered = 1'b1;
   logic [1:0]          fix_pins = 2'h0;
   logic [1:0]          dis_pins = 2'h0;
   logic [2:0]          oc_sense = 3'h0;
   logic                host_take = 1'b0;
   logic [7:0]          reg_rdata;
   logic [2:0]          oc_fault;
   hpc_pkg::hpc_report_t report;
   logic [5:0]          port_number;
   logic [1:0]          ports_seen;
   int                  fails = 0;
   int                  checks_done = 0;
   int                  cyc = 0;

   hpc_port_config uut (.clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .strap_mode, .self_powered, .fixed_attach_straps(fix_pins), .port_dis_straps(dis_pins),
      .oc_sense, .oc_fault, .report, .port_number);
   hpc_host_model host (.clk, .take(host_take), .report, .ports_seen);

   // 50 MHz clock and a hang guard
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         wrap_up;
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Bus cycles leave an idle cycle so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
      @(posedge clk);
   endtask
   // Pins need two sync edges and outputs one more, so five is ample
   task automatic outs(input logic [5:0] pn, input logic [5:0] rp, input string nm);
      repeat (5) @(posedge clk);
      #1 chk(nm, {2'h0, pn}, {2'h0, port_number});
      chk(nm, {2'h0, rp}, {2'h0, report});
      @(posedge clk);
   endtask

   task automatic t_regs;
      rd(8'he8, 8'h00, "dis_self");
      rd(8'he9, 8'h00, "dis_bus");
      rd(8'hfb, 8'h00, "map_12");
      rd(8'hfc, 8'h00, "map_3");
      wr(8'he5, 8'hff);
      rd(8'he5, 8'h3c, "cfg_two");
      // A write while the clock enable is low must not land
      clk_en <= 1'b0;
      wr(8'he5, 8'h00);
      clk_en <= 1'b1;
      rd(8'he5, 8'h3c, "cfg_frozen");
      wr(8'he6, 8'hff);
      rd(8'he6, 8'h08, "cfg_three");
      wr(8'he7, 8'hff);
      rd(8'he7, 8'h0e, "fixed");
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00, "unmapped");
   endtask
   task automatic t_std;
      wr(8'he6, 8'h00);
      wr(8'he5, 8'h08);
      wr(8'he7, 8'h02);
      wr(8'he8, 8'h04);
      outs(6'h21, 6'h31, "std_dis2");
      wr(8'he8, 8'h02);
      outs(6'h24, 6'h30, "std_dis1");
      self_powered <= 1'b0;
      outs(6'h39, 6'h39, "std_bus");
      host_take <= 1'b1;
      @(posedge clk);
      host_take <= 1'b0;
      #1 chk("host_ports", 8'h03, {6'h00, ports_seen});
      @(posedge clk);
   endtask
   task automatic t_remap;
      wr(8'he6, 8'h08);
      wr(8'hfb, 8'h13);
      wr(8'hfc, 8'h02);
      outs(6'h27, 6'h3c, "remap");
      rd(8'hf1, 8'h27, "map_out");
      wr(8'he6, 8'h00);
   endtask
   task automatic t_strap;
      strap_mode <= 1'b1;
      fix_pins <= 2'h2;
      dis_pins <= 2'h1;
      outs(6'h24, 6'h31, "strap_fix");
      rd(8'hf0, 8'he1, "status");
      fix_pins <= 2'h0;
      outs(6'h24, 6'h10, "strap_nofix");
      strap_mode <= 1'b0;
      dis_pins <= 2'h0;
   endtask
   task automatic t_oc;
      int n;
      int lim[4] = '{3, 5, 10, 20};
      for (int c = 0; c < 4; c++)
      begin
         wr(8'he5, 8'(c << 4));
         oc_sense <= 3'h7;
         n = 0;
         while (oc_fault[0] !== 1'b1 && n < 40)
         begin
            @(posedge clk);
            #1 n++;
         end
         checks_done++;
         if (n < lim[c] + 2 || n > lim[c] + 4)
         begin
            fails++;
            $display("BAD oc_delay exp %0d got %0d", lim[c] + 3, n);
         end
         chk("oc_all", 8'h07, {5'h00, oc_fault});
         @(posedge clk);
         oc_sense <= 3'h0;
         repeat (8) @(posedge clk);
         #1 chk("oc_clear", 8'h00, {5'h00, oc_fault});
         @(posedge clk);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_std;
      t_remap;
      t_strap;
      t_oc;
      wrap_up;
   end
endmodule
